// ==== cmf_regs.svh ====
// Constants for the clock mux fanout block
`ifndef CMF_REGS_SVH
`define CMF_REGS_SVH
`define CMF_NUM_OUTPUTS 5
`define CMF_SEL_DEFAULT 1'b1
`define CMF_OE_DEFAULT 1'b1
`define CMF_FAIL_TIMEOUT_NS 400
`define CMF_CLK_PERIOD_NS 40
`define CMF_FAIL_CYCLES ((`CMF_FAIL_TIMEOUT_NS + `CMF_CLK_PERIOD_NS - 1) / `CMF_CLK_PERIOD_NS)
`define CMF_CNT_W 8
`endif

// ==== cmf_pkg.sv ====
// Types for the clock mux fanout block
package cmf_pkg;
	typedef enum logic [1:0] {
		CMF_OFF,
		CMF_ARMED,
		CMF_ON
	} cmf_gate_t;
endpackage

// ==== cmf_fail_detect.sv ====
// Activity detector for the selected input clock
`timescale 1ns/100ps
`include "cmf_regs.svh"
module cmf_fail_detect #(
	parameter int CNT_W     = `CMF_CNT_W,
	parameter int FAIL_CYC  = `CMF_FAIL_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic clkIn,
	input  wire logic clkInN,
	output logic      failSafeHold,
	output logic      lastLevel
);
	logic             prevLevel;
	logic [CNT_W-1:0] idleCount;
	logic             validSwing;

	// Swing is valid only while the pair is truly complementary
	assign validSwing = clkIn ^ clkInN;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prevLevel <= 1'b0;
		end else if (validSwing) begin
			prevLevel <= clkIn;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			idleCount <= CNT_W'(FAIL_CYC); // [R7]
		end else if (validSwing && clkIn != prevLevel) begin
			idleCount <= '0; // [R9]
		end else if (idleCount != CNT_W'(FAIL_CYC)) begin
			idleCount <= idleCount + 1'b1; // [R7]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			failSafeHold <= 1'b1;
		end else begin
			failSafeHold <= !(validSwing && clkIn != prevLevel) &&
				(idleCount >= CNT_W'(FAIL_CYC - 1)); // [R7] [R9]
		end
	end

	assign lastLevel = prevLevel;
endmodule

// ==== cmf_fanout.sv ====
// Two-input clock selector with gated five-way fanout and fail-safe hold
// Behaviour
// R1: Five differential outputs each carry the selected input clock.
// R2: Select chooses the source; undriven select reads as high.
// R3: Select low follows input a, select high follows input b.
// R4: Disabled outputs hold true low and complement high.
// R5: Undriven output enable reads as high, outputs enabled.
// R6: Enable changes apply after a rising then a falling selected edge.
// R7: Stopped selected clock holds the outputs at a stable level.
// R8: Open input pair settles to a static level; outputs stay static.
// R9: Hold releases once valid transitions return on the selected input.
`timescale 1ns/100ps
`include "cmf_regs.svh"
module cmf_fanout #(
	parameter int NUM_OUT  = `CMF_NUM_OUTPUTS,
	parameter int FAIL_CYC = `CMF_FAIL_CYCLES
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               clockInA,
	input  wire logic               clockInANeg,
	input  wire logic               clockInB,
	input  wire logic               clockInBNeg,
	input  wire logic               sourceSel,
	input  wire logic               sourceSelDriven,
	input  wire logic               outEnable,
	input  wire logic               outEnableDriven,
	output logic [NUM_OUT-1:0]      fanoutOut,
	output logic [NUM_OUT-1:0]      fanoutOutNeg,
	output logic                    failSafeHold
);
	logic               selEff;
	logic               oeEff;
	logic               selIn;
	logic               selInNeg;
	logic               heldLevel;
	logic               clkLevel;
	logic               clkPrev;
	logic               sawRise;
	logic               gateOn;
	logic               oeTarget;
	cmf_pkg::cmf_gate_t gateState;
	cmf_pkg::cmf_gate_t next_gateState;

	// Pull-ups on the single-ended controls
	assign selEff = sourceSelDriven ? sourceSel : `CMF_SEL_DEFAULT; // [R2]
	assign oeEff  = outEnableDriven ? outEnable : `CMF_OE_DEFAULT;  // [R5]

	// Input multiplexer; the unselected pair is never looked at
	assign selIn    = selEff ? clockInB : clockInA;       // [R3]
	assign selInNeg = selEff ? clockInBNeg : clockInANeg; // [R3]

	cmf_fail_detect #(
		.FAIL_CYC (FAIL_CYC)
	) u_detect (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.clkIn        (selIn),
		.clkInN       (selInNeg),
		.failSafeHold (failSafeHold),
		.lastLevel    (heldLevel)
	);

	// Frozen at the last valid level while held; open pair gives static level
	assign clkLevel = failSafeHold ? heldLevel : selIn; // [R7] [R8]

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			clkPrev <= 1'b0;
		end else begin
			clkPrev <= clkLevel;
		end
	end

	// Enable synchroniser: wait for a rising then a falling edge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			oeTarget <= 1'b0;
		end else if (gateState != cmf_pkg::CMF_ARMED) begin
			oeTarget <= !gateOn;
		end
	end

	always_comb begin
		next_gateState = gateState;
		case (gateState)
			cmf_pkg::CMF_OFF: begin
				if (oeEff) begin
					next_gateState = cmf_pkg::CMF_ARMED;
				end
			end
			cmf_pkg::CMF_ON: begin
				if (!oeEff) begin
					next_gateState = cmf_pkg::CMF_ARMED;
				end
			end
			cmf_pkg::CMF_ARMED: begin
				if (sawRise && clkPrev && !clkLevel) begin
					next_gateState = oeTarget ? cmf_pkg::CMF_ON : cmf_pkg::CMF_OFF; // [R6]
				end
			end
			default: begin
				next_gateState = cmf_pkg::CMF_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			gateState <= cmf_pkg::CMF_OFF;
		end else begin
			gateState <= next_gateState;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sawRise <= 1'b0;
		end else if (gateState != cmf_pkg::CMF_ARMED) begin
			sawRise <= 1'b0;
		end else if (!clkPrev && clkLevel) begin
			sawRise <= 1'b1; // [R6]
		end
	end

	// While armed the outputs keep their old state until the edges arrive
	assign gateOn = (gateState == cmf_pkg::CMF_ON) ||
		(gateState == cmf_pkg::CMF_ARMED && !oeTarget); // [R6]

	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					fanoutOut[gi]    <= 1'b0;
					fanoutOutNeg[gi] <= 1'b1;
				end else begin
					fanoutOut[gi]    <= gateOn & clkLevel;    // [R1] [R4]
					fanoutOutNeg[gi] <= !(gateOn & clkLevel); // [R1] [R4]
				end
			end
		end
	endgenerate

	property p_disabled_low;
		@(posedge ref_clk) disable iff (!rst_n)
		!gateOn |=> (fanoutOut == '0 && fanoutOutNeg == '1);
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("disabled outputs not low"); // [R4]

	property p_copies;
		@(posedge ref_clk) disable iff (!rst_n)
		gateOn |=> (fanoutOut == {NUM_OUT{$past(clkLevel)}});
	endproperty
	a_copies: assert property (p_copies) else $error("outputs not copies of input"); // [R1]

	property p_complement;
		@(posedge ref_clk) disable iff (!rst_n)
		##1 (fanoutOutNeg == ~fanoutOut);
	endproperty
	a_complement: assert property (p_complement) else $error("output pair not complementary"); // [R1]

	property p_sel_a;
		@(posedge ref_clk) disable iff (!rst_n)
		(gateOn && !failSafeHold && sourceSelDriven && !sourceSel)
			|=> fanoutOut[0] == $past(clockInA);
	endproperty
	a_sel_a: assert property (p_sel_a) else $error("select low not following a"); // [R3]

	property p_sel_float;
		@(posedge ref_clk) disable iff (!rst_n)
		(gateOn && !failSafeHold && !sourceSelDriven) |=> fanoutOut[0] == $past(clockInB);
	endproperty
	a_sel_float: assert property (p_sel_float) else $error("open select not high"); // [R2]

	property p_oe_float;
		@(posedge ref_clk) disable iff (!rst_n)
		(!outEnableDriven && gateState == cmf_pkg::CMF_ON) |=> gateState == cmf_pkg::CMF_ON;
	endproperty
	a_oe_float: assert property (p_oe_float) else $error("open enable disabled outputs"); // [R5]

	property p_gate_edge;
		@(posedge ref_clk) disable iff (!rst_n)
		$changed(gateOn) |-> ($past(sawRise) && $past(clkPrev) && !$past(clkLevel));
	endproperty
	a_gate_edge: assert property (p_gate_edge) else $error("enable change without edges"); // [R6]

	property p_hold_static;
		@(posedge ref_clk) disable iff (!rst_n)
		failSafeHold [*2] |=> $stable(fanoutOut);
	endproperty
	a_hold_static: assert property (p_hold_static) else $error("outputs moved during hold"); // [R7] [R8]

	property p_release;
		@(posedge ref_clk) disable iff (!rst_n)
		(failSafeHold && (selIn ^ selInNeg) && selIn != heldLevel) |=> !failSafeHold;
	endproperty
	a_release: assert property (p_release) else $error("hold not released on edge"); // [R9]

	c_enable: cover property (@(posedge ref_clk) disable iff (!rst_n)
		gateState == cmf_pkg::CMF_OFF ##1 gateState == cmf_pkg::CMF_ARMED);
	c_on: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(gateOn));
	c_hold: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(failSafeHold));
	c_switch: cover property (@(posedge ref_clk) disable iff (!rst_n) gateOn && $changed(selEff));
endmodule

// ==== cmf_clk_src.sv ====
// Clock source model driving one differential input pair
`timescale 1ns/100ps
module cmf_clk_src #(
	parameter int HALF = 4
) (
	input  wire logic ref_clk,
	input  wire logic run,
	output logic      clk,
	output logic      clkN
);
	logic level = 1'b0;
	int   cnt   = 0;
	assign clk  = level;
	assign clkN = ~level;
	// Toggles slower than half the sampling rate; when stopped it holds a static level
	always @(posedge ref_clk) begin
		if (run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) begin
				level <= ~level;
			end
		end
	end
endmodule

// ==== cmf_fanout_tb.sv ====
// Self-checking testbench for the clock mux fanout block
`timescale 1ns/100ps
module cmf_fanout_tb;
	logic       ref_clk, rst_n, runA, runB, failSafeHold;
	logic       sourceSel, sourceSelDriven, outEnable, outEnableDriven;
	logic       clockInA, clockInANeg, clockInB, clockInBNeg;
	logic [4:0] fanoutOut, fanoutOutNeg;
	int         errors = 0;
	int         checks = 0;
	int         e;
	cmf_clk_src #(.HALF(4)) srcA (.ref_clk(ref_clk), .run(runA), .clk(clockInA),
		.clkN(clockInANeg));
	cmf_clk_src #(.HALF(3)) srcB (.ref_clk(ref_clk), .run(runB), .clk(clockInB),
		.clkN(clockInBNeg));
	cmf_fanout #(.NUM_OUT(5), .FAIL_CYC(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.clockInA(clockInA), .clockInANeg(clockInANeg), .clockInB(clockInB),
		.clockInBNeg(clockInBNeg), .sourceSel(sourceSel), .sourceSelDriven(sourceSelDriven),
		.outEnable(outEnable), .outEnableDriven(outEnableDriven), .fanoutOut(fanoutOut),
		.fanoutOutNeg(fanoutOutNeg), .failSafeHold(failSafeHold));
	task check(string name, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task test_done;
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Inputs as {sel, selDriven, oe, oeDriven, runA, runB}
	task drive(logic [5:0] v);
		@(posedge ref_clk);
		{sourceSel, sourceSelDriven, outEnable, outEnableDriven, runA, runB} <= v;
	endtask
	// Counts output edges over n cycles and checks copies and complements
	task watch(int n, output int edges);
		logic [4:0] prev;
		edges = 0;
		prev = fanoutOut;
		repeat (n) begin
			@(negedge ref_clk);
			if (fanoutOut !== prev) edges++;
			prev = fanoutOut;
			if (fanoutOut !== 5'h00) check("copies", fanoutOut, 5'h1f);
			check("complement", fanoutOutNeg ^ fanoutOut, 5'h1f);
		end
	endtask
	task t_reset;
		@(negedge ref_clk);
		check("reset out", fanoutOut, 5'h00);
		check("reset hold", failSafeHold, 1'b1);
	endtask
	task t_select;
		drive(6'h1e);
		watch(64, e);
		check("a edges", e > 0, 1'b1);
		check("a hold", failSafeHold, 1'b0);
		drive(6'h1d);
		watch(16, e);
		watch(32, e);
		check("a stopped edges", e, 0);
		check("a stopped hold", failSafeHold, 1'b1);
		drive(6'h3d);
		watch(32, e);
		check("b edges", e > 0, 1'b1);
		check("b hold", failSafeHold, 1'b0);
		drive(6'h0d);
		watch(32, e);
		check("open select", e > 0, 1'b1);
	endtask
	task t_enable;
		@(posedge clockInB);
		drive(6'h3c);
		watch(16, e);
		check("frozen high", fanoutOut, 5'h1f);
		drive(6'h34);
		watch(16, e);
		check("no clock no disable", fanoutOut, 5'h1f);
		drive(6'h35);
		watch(24, e);
		check("disabled", fanoutOutNeg, 5'h1f);
		watch(24, e);
		check("disabled edges", e, 0);
		drive(6'h31);
		watch(32, e);
		check("open enable", e > 0, 1'b1);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		errors++;
		test_done;
	end
	initial begin
		rst_n = 1'b0;
		{sourceSel, sourceSelDriven, outEnable, outEnableDriven, runA, runB} = 6'h1c;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset;
		t_select;
		t_enable;
		test_done;
	end
endmodule
